// File: rtl/pdm_pkg.sv
package pdm_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [15:0] SYSTEM_CONTROL_ADDR = 16'hFFF2;
   localparam logic [7:0]  SYSTEM_CONTROL_RST  = 8'h0B;
   localparam int          STANDBY_SEL_POS     = 7;
   localparam int          SETTLE_HI_POS       = 6;
   localparam int          SETTLE_LO_POS       = 4;
   localparam int          MEM_ON_POS          = 0;
   localparam logic [7:0]  UNMAPPED_READ       = 8'h00;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int PRESCALE_BITS  = 12;
   localparam int SETTLE_BITS    = 18;
   localparam int DUTY_MHZ_MIN   = 5;
   localparam int SETTLE_BASE    = 8192;
   localparam int SETTLE_MAX     = 131072;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      PDM_RUN    = 5'b00001,
      PDM_SLEEP  = 5'b00010,
      PDM_SWSTBY = 5'b00100,
      PDM_SETTLE = 5'b01000,
      PDM_HWSTBY = 5'b10000
   } pdm_mode_e;

   typedef struct packed {
      logic cpu_halt;
      logic cpu_reset;
      logic clk_stop;
      logic dma_halt;
      logic dma_reset;
      logic refresh_halt;
      logic refresh_init;
      logic periph_halt;
      logic periph_reset;
      logic ports_hiz;
   } pdm_ctrl_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } pdm_bus_s;

   function automatic logic [SETTLE_BITS-1:0] settle_count
      (input logic [2:0] code);
      logic [SETTLE_BITS-1:0] base;
      base = SETTLE_BITS'(SETTLE_BASE);
      if (code[2])
         settle_count = SETTLE_BITS'(SETTLE_MAX);
      else
         settle_count = base << code[1:0];
   endfunction : settle_count
endpackage : pdm_pkg

// File: rtl/pdm_prescaler.sv
`timescale 1ns/1ns
module pdm_prescaler
   import pdm_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire logic                     run,
   output logic [PRESCALE_BITS-1:0]      div_ticks
);
   typedef struct packed {
      logic [PRESCALE_BITS-1:0] cnt;
      logic [PRESCALE_BITS-1:0] tick;
   } pdm_pre_s;

   pdm_pre_s st_r;
   pdm_pre_s st_nxt;

   // bit k of tick pulses once every 2^(k+1) clocks: phi/2 .. phi/4096
   always_comb
   begin
      st_nxt = st_r;
      if (!run)
      begin
         st_nxt.cnt  = '0;
         st_nxt.tick = '0;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + PRESCALE_BITS'(1);
         // running and of the low bits keeps every part-select constant
         st_nxt.tick[0] = st_r.cnt[0];
         for (int k = 1; k < PRESCALE_BITS; k++)
            st_nxt.tick[k] = st_nxt.tick[k-1] & st_r.cnt[k];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign div_ticks = st_r.tick;

   a_div2_alternates: assert property (@(posedge clk) disable iff (!rstn)
      run && $past(run) && div_ticks[0] |=> !div_ticks[0])
      else $error("phi/2 tick not alternating");
endmodule : pdm_prescaler

// File: rtl/pdm_duty_adjust.sv
`timescale 1ns/1ns
module pdm_duty_adjust
   import pdm_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic osc_fast,
   input  wire logic osc_raw,
   output logic      sys_clk_en
);
   typedef struct packed {
      logic ph;
      logic en;
   } pdm_duty_s;

   pdm_duty_s st_r;
   pdm_duty_s st_nxt;

   // fast oscillators get a regenerated 50 percent phase instead of raw
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.ph = ~st_r.ph;
      st_nxt.en = osc_fast ? st_r.ph : osc_raw;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign sys_clk_en = st_r.en;

   // the phase restarts at reset, so two clean updates are needed first
   a_duty_balanced: assert property (@(posedge clk) disable iff (!rstn)
      osc_fast && $past(osc_fast) && $past(osc_fast, 2)
      && $past(rstn) && $past(rstn, 2)
      |-> sys_clk_en != $past(sys_clk_en))
      else $error("corrected clock not balanced");
endmodule : pdm_duty_adjust

// File: rtl/pdm_top.sv
`timescale 1ns/1ns
// Function
// - prescalers give phi/2 through phi/4096
// - duty corrected at 5 MHz or faster
// - halt with select 0 enters sleep
// - halt with select 1 enters software standby
// - sleep halts CPU only; any wake ends
// - software standby stops clock, resets peripherals
// - standby initialises refresh counter, top bits
// - select bit stays set after wake
// - only write, reset or low standby pin clears select
// - wait code maps 8192 to 131072 states
// - wait applies only on interrupt wake
// - control register 8 bit, reset 0x0B
// - low standby pin forces hardware standby
// - wake counts wait then starts handling
// - pin rise with reset low restarts oscillator
module pdm_top
   import pdm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [15:0]       bus_addr,
   input  wire logic [7:0]        bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output logic      [7:0]        bus_rdata,
   input  wire logic              halt_done,
   input  wire logic              any_irq,
   input  wire logic              nmi_req,
   input  wire logic [2:0]        ext_int_lines,
   input  wire logic              chip_init_pin_n,
   input  wire logic              standby_pin_n,
   input  wire logic              osc_fast,
   input  wire logic              osc_raw,
   output logic                   sys_clk_en,
   output logic [PRESCALE_BITS-1:0] div_ticks,
   output pdm_ctrl_s              unit_ctrl,
   output pdm_mode_e              mode,
   output logic                   osc_run,
   output logic                   irq_handling,
   output logic                   onchip_memory_on_bit
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      pdm_mode_e              mode;
      logic [7:0]             system_control;
      logic [SETTLE_BITS-1:0] wait_cnt;
      logic                   osc_run;
      logic                   irq_go;
      logic [7:0]             rdata;
      pdm_ctrl_s              ctrl;
   } pdm_state_s;

   pdm_state_s st_r;
   pdm_state_s st_nxt;
   pdm_bus_s   bus;
   logic       sw_wake;
   logic       clk_live;

   assign bus     = '{addr: bus_addr, wdata: bus_wdata,
                      wr: bus_wr, rd: bus_rd};
   assign sw_wake = nmi_req | (|ext_int_lines);
   // taken from the next state so the ticks stop on the entry edge
   assign clk_live = !st_nxt.ctrl.clk_stop;

   // ---------------------------------------------------------------
   // control units per mode
   // ---------------------------------------------------------------
   function automatic pdm_ctrl_s ctrl_for(input pdm_mode_e m);
      pdm_ctrl_s c;
      c = '0;
      unique case (m)
         PDM_RUN: ;
         PDM_SLEEP:
            c.cpu_halt = 1'b1;
         PDM_SWSTBY, PDM_SETTLE:
         begin
            c.cpu_halt     = 1'b1;
            c.clk_stop     = 1'b1;
            c.dma_halt     = 1'b1;
            c.dma_reset    = 1'b1;
            c.refresh_halt = 1'b1;
            c.periph_halt  = 1'b1;
            c.periph_reset = 1'b1;
         end
         PDM_HWSTBY:
         begin
            c = '1;
            c.refresh_init = 1'b1;
         end
      endcase
      ctrl_for = c;
   endfunction : ctrl_for

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.irq_go = 1'b0;
      st_nxt.rdata  = UNMAPPED_READ;

      // register slave: one byte at its printed address
      if (bus.wr && bus.addr == SYSTEM_CONTROL_ADDR
          && st_r.mode == PDM_RUN)
         st_nxt.system_control = bus.wdata;
      if (bus.rd && bus.addr == SYSTEM_CONTROL_ADDR)
         st_nxt.rdata = st_r.system_control;

      unique case (st_r.mode)
         PDM_RUN:
            if (halt_done)
            begin
               // select sampled at completion of the halt
               if (st_r.system_control[STANDBY_SEL_POS])
                  st_nxt.mode = PDM_SWSTBY;
               else
                  st_nxt.mode = PDM_SLEEP;
            end
         PDM_SLEEP:
            if (any_irq || sw_wake)
            begin
               st_nxt.mode   = PDM_RUN;
               st_nxt.irq_go = 1'b1;
            end
         PDM_SWSTBY:
         begin
            st_nxt.osc_run = 1'b0;
            if (sw_wake)
            begin
               st_nxt.mode     = PDM_SETTLE;
               st_nxt.osc_run  = 1'b1;
               st_nxt.wait_cnt = settle_count(
                  st_r.system_control[SETTLE_HI_POS:SETTLE_LO_POS]);
            end
         end
         PDM_SETTLE:
            if (st_r.wait_cnt <= SETTLE_BITS'(1))
            begin
               // select bit kept: wake does not touch it
               st_nxt.mode   = PDM_RUN;
               st_nxt.irq_go = 1'b1;
               st_nxt.wait_cnt = '0;
            end
            else
               st_nxt.wait_cnt = st_r.wait_cnt - SETTLE_BITS'(1);
         PDM_HWSTBY:
         begin
            st_nxt.osc_run = 1'b0;
            // oscillator restarts once the pin rises under reset
            if (standby_pin_n && !chip_init_pin_n)
               st_nxt.osc_run = 1'b1;
         end
      endcase

      // chip reset pin wakes any mode but hardware standby into reset state
      if (!chip_init_pin_n && st_r.mode != PDM_HWSTBY)
      begin
         st_nxt.mode           = PDM_RUN;
         st_nxt.osc_run        = 1'b1;
         st_nxt.wait_cnt       = '0;
         st_nxt.system_control = SYSTEM_CONTROL_RST;
      end
      // the pin always wins, whatever the mode
      if (!standby_pin_n)
      begin
         st_nxt.mode           = PDM_HWSTBY;
         st_nxt.osc_run        = 1'b0;
         st_nxt.wait_cnt       = '0;
         // memory enable is kept so retained data stays guarded
         st_nxt.system_control = {SYSTEM_CONTROL_RST[7:1],
                                  st_r.system_control[MEM_ON_POS]};
      end
      // leaving pin standby only when reset releases
      if (st_r.mode == PDM_HWSTBY && standby_pin_n && chip_init_pin_n)
      begin
         st_nxt.mode    = PDM_RUN;
         st_nxt.osc_run = 1'b1;
      end
      st_nxt.ctrl = ctrl_for(st_nxt.mode);
      // refresh counter and top timer bits initialised on software standby entry and on every cycle of hardware standby
      st_nxt.ctrl.refresh_init = (st_nxt.mode == PDM_SWSTBY
         && st_r.mode == PDM_RUN) || st_nxt.mode == PDM_HWSTBY;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_r.mode           <= PDM_RUN;
         st_r.system_control <= SYSTEM_CONTROL_RST;
         st_r.wait_cnt       <= '0;
         st_r.osc_run        <= 1'b1;
         st_r.irq_go         <= 1'b0;
         st_r.rdata          <= 8'h00;
         st_r.ctrl           <= '0;
      end
      else
         st_r <= st_nxt;
   end

   // ---------------------------------------------------------------
   // clock path
   // ---------------------------------------------------------------
   // prescalers clear and hold at zero while the clock is stopped in standby
   pdm_prescaler u_pre (
      .clk       (clk),
      .rstn      (rstn),
      .run       (clk_live),
      .div_ticks (div_ticks)
   );

   pdm_duty_adjust u_duty (
      .clk        (clk),
      .rstn       (rstn),
      .osc_fast   (osc_fast),
      .osc_raw    (osc_raw),
      .sys_clk_en (sys_clk_en)
   );

   assign bus_rdata            = st_r.rdata;
   assign unit_ctrl            = st_r.ctrl;
   assign mode                 = st_r.mode;
   assign osc_run              = st_r.osc_run;
   assign irq_handling         = st_r.irq_go;
   assign onchip_memory_on_bit = st_r.system_control[MEM_ON_POS];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_halt_sleep: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_RUN && halt_done && chip_init_pin_n && standby_pin_n
      && !st_r.system_control[STANDBY_SEL_POS] |=> mode == PDM_SLEEP)
      else $error("halt with select 0 missed sleep");

   a_halt_swstby: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_RUN && halt_done && chip_init_pin_n && standby_pin_n
      && st_r.system_control[STANDBY_SEL_POS] |=> mode == PDM_SWSTBY)
      else $error("halt with select 1 missed standby");

   a_sleep_units: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SLEEP |-> unit_ctrl.cpu_halt && !unit_ctrl.clk_stop
      && !unit_ctrl.dma_halt && !unit_ctrl.periph_halt)
      else $error("sleep unit controls wrong");

   a_sleep_wake: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SLEEP && any_irq && standby_pin_n && chip_init_pin_n
      |=> mode == PDM_RUN && irq_handling)
      else $error("interrupt did not end sleep");

   a_swstby_units: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SWSTBY |-> unit_ctrl.clk_stop && unit_ctrl.dma_reset
      && unit_ctrl.periph_reset && !unit_ctrl.cpu_reset)
      else $error("software standby controls wrong");

   a_swstby_wait: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SWSTBY && !sw_wake && standby_pin_n && chip_init_pin_n
      |=> mode == PDM_SWSTBY)
      else $error("software standby left without wake source");

   a_clock_frozen: assert property (@(posedge clk) disable iff (!rstn)
      unit_ctrl.clk_stop |-> div_ticks == '0)
      else $error("prescaler ticks while clock stopped");

   a_reset_pin: assert property (@(posedge clk) disable iff (!rstn)
      !chip_init_pin_n && standby_pin_n && mode != PDM_HWSTBY
      |=> mode == PDM_RUN && st_r.system_control == SYSTEM_CONTROL_RST)
      else $error("reset pin did not reinitialise");

   a_refresh_init: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_RUN ##1 mode == PDM_SWSTBY
      |-> unit_ctrl.refresh_init && unit_ctrl.refresh_halt)
      else $error("refresh not initialised on standby");

   a_refresh_once: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SWSTBY ##1 mode == PDM_SWSTBY
      |-> !unit_ctrl.refresh_init && unit_ctrl.refresh_halt)
      else $error("refresh settings not held in standby");

   a_hw_units: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_HWSTBY |-> unit_ctrl.ports_hiz && unit_ctrl.cpu_reset)
      else $error("hardware standby controls wrong");

   a_select_kept: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SETTLE ##1 mode == PDM_RUN
      |-> st_r.system_control[STANDBY_SEL_POS])
      else $error("select bit cleared on wake");

   a_select_clear: assert property (@(posedge clk) disable iff (!rstn)
      $fell(st_r.system_control[STANDBY_SEL_POS])
      |-> $past(bus_wr) || !$past(chip_init_pin_n)
      || !$past(standby_pin_n))
      else $error("select bit cleared by hardware");

   a_write_blocked: assert property (@(posedge clk) disable iff (!rstn)
      bus_wr && mode != PDM_RUN && standby_pin_n && chip_init_pin_n
      |=> $stable(st_r.system_control))
      else $error("register written outside run");

   a_settle_load: assert property (@(posedge clk)
      disable iff (!rstn)
      mode == PDM_SWSTBY && sw_wake && standby_pin_n && chip_init_pin_n
      |=> mode == PDM_SETTLE && st_r.wait_cnt == settle_count(
      $past(st_r.system_control[SETTLE_HI_POS:SETTLE_LO_POS])))
      else $error("wait count not loaded");

   a_settle_count: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SETTLE && st_r.wait_cnt > SETTLE_BITS'(1)
      && standby_pin_n && chip_init_pin_n
      |=> st_r.wait_cnt == $past(st_r.wait_cnt) - SETTLE_BITS'(1))
      else $error("settle wait not counting down");

   a_read_data: assert property (@(posedge clk) disable iff (!rstn)
      bus_rd && bus_addr == SYSTEM_CONTROL_ADDR
      |=> bus_rdata == $past(st_r.system_control))
      else $error("register read data wrong");

   a_settle_end: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_SETTLE && st_r.wait_cnt == 18'h00001 && standby_pin_n
      && chip_init_pin_n |=> mode == PDM_RUN && irq_handling)
      else $error("settle end missed handling");

   a_pin_standby: assert property (@(posedge clk) disable iff (!rstn)
      !standby_pin_n |=> mode == PDM_HWSTBY)
      else $error("pin did not force standby");

   a_osc_restart: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_HWSTBY && standby_pin_n && !chip_init_pin_n
      |=> osc_run)
      else $error("oscillator not restarted");

   a_hw_exit: assert property (@(posedge clk) disable iff (!rstn)
      mode == PDM_HWSTBY && standby_pin_n && chip_init_pin_n
      |=> mode == PDM_RUN && osc_run)
      else $error("pin standby not left on reset release");
endmodule : pdm_top

// File: dv/pdm_pin_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// reset and standby pin drivers
// ---------------------------------------------------------------
module pdm_pin_model
#(
   // 10000 cycles of 50 ns keep reset low 500 us, the short pulse included
   parameter int HOLD = 10000
)
(
   input  wire logic clk,
   input  wire logic enter,
   input  wire logic leave,
   output logic      init_pin_n,
   output logic      standby_pin_n_pin_n,
   output logic      idle
);
   logic [1:0] ph_r;
   int         cnt_r;

   initial
   begin
      init_pin_n = 1'b1;
      standby_pin_n_pin_n = 1'b1;
      ph_r       = 2'h0;
      cnt_r      = 0;
   end

   assign idle = (ph_r == 2'h0);

   // reset goes low before standby and rises only after the settle hold
   always @(posedge clk)
   begin
      cnt_r <= cnt_r + 1;
      case (ph_r)
         2'h0:
            if (enter)
            begin
               init_pin_n <= 1'b0;
               cnt_r      <= 0;
               ph_r       <= 2'h1;
            end
         2'h1:
            if (cnt_r == HOLD - 1)
            begin
               standby_pin_n_pin_n <= 1'b0;
               ph_r       <= 2'h2;
            end
         2'h2:
            if (leave)
            begin
               standby_pin_n_pin_n <= 1'b1;
               cnt_r      <= 0;
               ph_r       <= 2'h3;
            end
         default:
            if (cnt_r == HOLD - 1)
            begin
               init_pin_n <= 1'b1;
               ph_r       <= 2'h0;
            end
      endcase
   end
endmodule : pdm_pin_model

// File: dv/pdm_top_test.sv
`timescale 1ns/1ns
module pdm_top_test
   import pdm_pkg::*;
;
   logic                     clk = 1'b0;
   logic                     rstn = 1'b0;
   logic [15:0]              bus_addr;
   logic [7:0]               bus_wdata;
   logic                     bus_wr, bus_rd, halt_done, any_irq, nmi_req;
   logic [2:0]               ext_int_lines;
   logic                     osc_fast, osc_raw, enter, leave;
   logic [7:0]               bus_rdata, d;
   logic                     sys_clk_en, osc_run, irq_handling, mem_on;
   logic [PRESCALE_BITS-1:0] div_ticks;
   pdm_ctrl_s                unit_ctrl;
   pdm_mode_e                mode;
   logic                     init_n, standby_pin_n_n, idle, s0;
   int                       error_cnt = 0;
   int                       n_compared = 0;
   int                       n;

   always #25 clk = ~clk;

   pdm_top i_pdm_top (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .halt_done(halt_done), .any_irq(any_irq),
      .nmi_req(nmi_req), .ext_int_lines(ext_int_lines),
      .chip_init_pin_n(init_n), .standby_pin_n(standby_pin_n_n),
      .osc_fast(osc_fast), .osc_raw(osc_raw), .sys_clk_en(sys_clk_en),
      .div_ticks(div_ticks), .unit_ctrl(unit_ctrl), .mode(mode),
      .osc_run(osc_run), .irq_handling(irq_handling),
      .onchip_memory_on_bit(mem_on));

   pdm_pin_model i_pdm_pin_model (.clk(clk), .enter(enter), .leave(leave),
      .init_pin_n(init_n), .standby_pin_n_pin_n(standby_pin_n_n), .idle(idle));

   task summarize;
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] v);
      @(posedge clk);
      bus_addr  <= SYSTEM_CONTROL_ADDR;
      bus_wdata <= v;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask : wr

   task rd(input logic [15:0] a);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // one-cycle pulse; returns just after the edge that samples it
   task pulse(input int which);
      @(posedge clk);
      halt_done        <= (which == 0);
      any_irq          <= (which == 1);
      ext_int_lines[1] <= (which == 2);
      enter            <= (which == 3);
      leave            <= (which == 4);
      nmi_req          <= (which == 5);
      @(posedge clk);
      {halt_done, any_irq, ext_int_lines[1], enter, leave, nmi_req} <= 6'h00;
      #1;
   endtask : pulse

   task t_reset;
      rd(SYSTEM_CONTROL_ADDR);
      chk("sysctl", SYSTEM_CONTROL_RST, d);
      chk("mode", PDM_RUN, mode);
      chk("osc", 1'b1, osc_run);
      rd(16'hFFF0);
      chk("unmapped", UNMAPPED_READ, d);
   endtask : t_reset

   task t_clock;
      @(posedge clk);
      #1 s0 = sys_clk_en;
      n = 0;
      @(posedge clk);
      #1 chk("duty", !s0, sys_clk_en);
      repeat (4)
      begin
         n += div_ticks[0] + 2 * div_ticks[1];
         @(posedge clk);
         #1;
      end
      chk("ticks", 4, n);
      @(posedge clk);
      osc_fast <= 1'b0;
      osc_raw  <= 1'b1;
      @(posedge clk);
      #1 chk("raw", 1'b1, sys_clk_en);
      @(posedge clk);
      osc_fast <= 1'b1;
   endtask : t_clock

   task t_sleep;
      wr(8'h0B);
      pulse(0);
      chk("mode", PDM_SLEEP, mode);
      chk("ctrl", 10'h200, unit_ctrl);
      wr(8'h8B);
      pulse(1);
      chk("mode", PDM_RUN, mode);
      chk("irq", 1'b1, irq_handling);
      rd(SYSTEM_CONTROL_ADDR);
      chk("sysctl", 8'h0B, d);
   endtask : t_sleep

   task t_swstby;
      // external clock in the bench, so any wait code is legal
      wr(8'h9B);
      pulse(0);
      chk("mode", PDM_SWSTBY, mode);
      chk("ctrl", 10'h2FE, unit_ctrl);
      chk("refinit", 1'b1, unit_ctrl.refresh_init);
      chk("ticks", 0, div_ticks);
      pulse(1);
      chk("mode", PDM_SWSTBY, mode);
      pulse(2);
      chk("mode", PDM_SETTLE, mode);
      chk("osc", 1'b1, osc_run);
      // code 001 waits 16384 states before handling starts
      for (n = 0; n < 20000 && mode !== PDM_RUN; n++)
         @(posedge clk) #1;
      chk("settle", 16384, n);
      chk("irq", 1'b1, irq_handling);
      rd(SYSTEM_CONTROL_ADDR);
      chk("sysctl", 8'h9B, d);
      wr(8'h1B);
      rd(SYSTEM_CONTROL_ADDR);
      chk("sysctl", 8'h1B, d);
      // code 000 and a wake by the nonmaskable request
      wr(8'h8B);
      pulse(0);
      chk("mode", PDM_SWSTBY, mode);
      pulse(5);
      chk("mode", PDM_SETTLE, mode);
      for (n = 0; n < 20000 && mode !== PDM_RUN; n++)
         @(posedge clk) #1;
      chk("settle", 8192, n);
      chk("irq", 1'b1, irq_handling);
   endtask : t_swstby

   task t_hw;
      wr(8'h0A);
      #1 chk("memon", 1'b0, mem_on);
      pulse(3);
      for (n = 0; n < 20000 && standby_pin_n_n; n++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      #1 chk("mode", PDM_HWSTBY, mode);
      chk("ctrl", 10'h3FF, unit_ctrl);
      chk("osc", 1'b0, osc_run);
      pulse(4);
      repeat (2) @(posedge clk);
      #1 chk("osc", 1'b1, osc_run);
      chk("mode", PDM_HWSTBY, mode);
      for (n = 0; n < 20000 && !idle; n++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      #1 chk("mode", PDM_RUN, mode);
      rd(SYSTEM_CONTROL_ADDR);
      chk("sysctl", SYSTEM_CONTROL_RST, d);
      chk("memon", 1'b1, mem_on);
   endtask : t_hw

   initial
   begin
      {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
      {halt_done, any_irq, nmi_req, ext_int_lines} = '0;
      {osc_raw, enter, leave} = '0;
      osc_fast = 1'b1;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_clock();
      t_sleep();
      t_swstby();
      t_hw();
      summarize();
   end

   // two settle waits and two pin holds take about 45000 cycles
   initial
   begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      summarize();
   end
endmodule : pdm_top_test
